/* File: dv/ocs_host_model.sv */
/*
 * Host controller and load: turns commands into control inputs and
 * current comparator levels.
 * Assumes the bench changes cmd and the load faults off the clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module ocs_host_model
   import ocs_pkg::*;
(
   input wire logic [ocs_pkg::NUM_CH-1:0] cmd,
   input wire logic [ocs_pkg::NUM_CH-1:0] short_ld,
   input wire logic [ocs_pkg::NUM_CH-1:0] peak_ld,
   output logic [ocs_pkg::NUM_CH-1:0] channel_control_input,
   output logic [ocs_pkg::NUM_CH-1:0] over_limit_detect,
   output logic [ocs_pkg::NUM_CH-1:0] over_peak_limit
);
   assign channel_control_input = cmd;
   // Load current only flows in a commanded channel.
   assign over_limit_detect = short_ld & cmd;
   assign over_peak_limit = peak_ld & cmd;
endmodule
`default_nettype wire

/* File: dv/ocs_top_properties.sv */
/*
 * Concurrent checks on the ports of ocs_top, channel 0 in detail.
 * Assumes one clock, sys_clk, and synchronous active-low rst_n.
 */
`timescale 1ns/1ps
`default_nettype none
module ocs_top_properties
   import ocs_pkg::*;
#(
   parameter ocs_pkg::ocs_cnt_t LIMIT_PULSE_CYC = 24'h000004,
   parameter ocs_pkg::ocs_cnt_t PEAK_TEST_CYC = 24'h000003,
   parameter ocs_pkg::ocs_cnt_t PEAK_LIMIT_CYC = 24'h000014
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [ocs_pkg::NUM_CH-1:0] channel_control_input,
   input wire logic [ocs_pkg::NUM_CH-1:0] over_limit_detect,
   input wire logic [ocs_pkg::NUM_CH-1:0] over_peak_limit,
   input wire logic [ocs_pkg::NUM_CH-1:0] clamp_over_threshold,
   input wire logic [ocs_pkg::NUM_CH-1:0] output_beyond_high_clamp,
   input wire logic [ocs_pkg::NUM_CH-1:0] channel_output,
   input wire logic [ocs_pkg::NUM_CH-1:0] normal_limit_active,
   input wire logic [ocs_pkg::NUM_CH-1:0] peak_limit_active,
   input wire logic [ocs_pkg::NUM_CH-1:0] overcurrent_shutdown_flag,
   input wire logic [ocs_pkg::NUM_CH-1:0] clamp_low_select,
   input wire logic [ocs_pkg::NUM_CH-1:0] clamp_engage,
   input wire logic fault_indicator_n_oe_n
);
   // ---------------------------------------------------------------
   // Pulse length counters
   // ---------------------------------------------------------------
   ocs_cnt_t lim_cnt_reg;
   ocs_cnt_t pk_cnt_reg;
   ocs_cnt_t pl_cnt_reg;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !(normal_limit_active[0] && over_limit_detect[0])) begin
         lim_cnt_reg <= CNT_RST;
      end else begin
         lim_cnt_reg <= lim_cnt_reg + CNT_ONE;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !(peak_limit_active[0] && over_peak_limit[0])) begin
         pk_cnt_reg <= CNT_RST;
      end else begin
         pk_cnt_reg <= pk_cnt_reg + CNT_ONE;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !peak_limit_active[0]) begin
         pl_cnt_reg <= CNT_RST;
      end else begin
         pl_cnt_reg <= pl_cnt_reg + CNT_ONE;
      end
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   AST_LIMIT_PULSE: assert property (lim_cnt_reg <= LIMIT_PULSE_CYC)
      else $error("limit pulse too long");
   AST_LIMIT_EXPIRY: assert property (lim_cnt_reg == LIMIT_PULSE_CYC &&
      $past(channel_control_input[0]) |-> overcurrent_shutdown_flag[0] &&
      !channel_output[0] && !fault_indicator_n_oe_n)
      else $error("no shutdown after limit pulse");
   AST_PEAK_TEST: assert property (pk_cnt_reg <= PEAK_TEST_CYC)
      else $error("peak test pulse too long");
   AST_PEAK_LIMIT: assert property (pl_cnt_reg <= PEAK_LIMIT_CYC)
      else $error("peak limit pulse too long");
   AST_RETRY_DELAY: assert property ($rose(overcurrent_shutdown_flag[0])
      |-> !channel_output[0] [*8])
      else $error("channel on within retry delay");
   AST_RELEASE_FULL_ON: assert property (normal_limit_active[0] &&
      !over_limit_detect[0] && channel_control_input[0]
      |=> channel_output[0] && !normal_limit_active[0])
      else $error("no return to full on");
   AST_ON_ENGAGES_LIMIT: assert property ($rose(channel_control_input[0])
      && over_limit_detect[0] && !overcurrent_shutdown_flag[0]
      |=> normal_limit_active[0] && channel_output[0])
      else $error("no limit at turn on");
   AST_CLAMP_LOW: assert property ($past(rst_n) |-> clamp_low_select ==
      $past(~channel_output & clamp_over_threshold))
      else $error("clamp level select wrong");
   AST_CLAMP_ENGAGE: assert property ($past(rst_n) |-> clamp_engage ==
      $past(~channel_output & output_beyond_high_clamp))
      else $error("off state clamp wrong");
   AST_FAULT_HOLD: assert property ($rose(overcurrent_shutdown_flag[0])
      |-> !fault_indicator_n_oe_n [*8])
      else $error("fault pin released early");
   cover property ($rose(overcurrent_shutdown_flag[0]));
   cover property ($rose(peak_limit_active[0]));
   cover property ($rose(clamp_engage[0]));
endmodule
bind ocs_top ocs_top_properties #(
   .LIMIT_PULSE_CYC(LIMIT_PULSE_CYC),
   .PEAK_TEST_CYC(PEAK_TEST_CYC),
   .PEAK_LIMIT_CYC(PEAK_LIMIT_CYC)
) u_props (
   .sys_clk(sys_clk), .rst_n(rst_n),
   .channel_control_input(channel_control_input),
   .over_limit_detect(over_limit_detect),
   .over_peak_limit(over_peak_limit),
   .clamp_over_threshold(clamp_over_threshold),
   .output_beyond_high_clamp(output_beyond_high_clamp),
   .channel_output(channel_output),
   .normal_limit_active(normal_limit_active),
   .peak_limit_active(peak_limit_active),
   .overcurrent_shutdown_flag(overcurrent_shutdown_flag),
   .clamp_low_select(clamp_low_select), .clamp_engage(clamp_engage),
   .fault_indicator_n_oe_n(fault_indicator_n_oe_n)
);
`default_nettype wire

/* File: dv/ocs_top_test.sv */
/*
 * Self-checking bench for ocs_top with shortened protection times.
 * Assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none
module ocs_top_test;
   import ocs_pkg::*;
   localparam ocs_cnt_t LP = 24'h000004;
   localparam ocs_cnt_t PT = 24'h000003;
   localparam ocs_cnt_t PL = 24'h000014;
   localparam int TIMEOUT_CYC = 3000;
   logic sys_clk = 1'b0;
   logic rst_n;
   logic [NUM_CH-1:0] cmd, short_ld, peak_ld, clamp_over, beyond;
   logic [NUM_CH-1:0] ctl, det, opk, ch_out, nl_act, pk_act, sd_flag;
   logic [NUM_CH-1:0] cl_low, cl_eng;
   logic over_temp, diag_clear, flt_out, flt_oe_n;
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #10 sys_clk = ~sys_clk;
   ocs_host_model host (.cmd(cmd), .short_ld(short_ld), .peak_ld(peak_ld),
      .channel_control_input(ctl), .over_limit_detect(det),
      .over_peak_limit(opk));
   ocs_top #(.LIMIT_PULSE_CYC(LP), .DELAY_CYC(24'h000008),
      .PERIOD_CYC(24'h000010), .WINDOW_CYC(24'h000040),
      .PEAK_TEST_CYC(PT), .PEAK_LIMIT_CYC(PL), .HOLD_CYC(24'h00000a)) uut (
      .sys_clk(sys_clk), .rst_n(rst_n), .channel_control_input(ctl),
      .over_limit_detect(det), .over_peak_limit(opk),
      .clamp_over_threshold(clamp_over), .output_beyond_high_clamp(beyond),
      .over_temp_any(over_temp), .diag_clear(diag_clear),
      .channel_output(ch_out), .normal_limit_active(nl_act),
      .peak_limit_active(pk_act), .overcurrent_shutdown_flag(sd_flag),
      .clamp_low_select(cl_low), .clamp_engage(cl_eng),
      .fault_indicator_n_out(flt_out), .fault_indicator_n_oe_n(flt_oe_n));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic close_out;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   function automatic logic pick(input int sel);
      case (sel)
         0: return ch_out[0];
         1: return pk_act[0];
         default: return sd_flag[0];
      endcase
   endfunction
   task automatic wait_for(input int sel, input logic v, input int lim);
      int i;
      i = 0;
      while (pick(sel) !== v && i < lim) begin
         @(negedge sys_clk);
         i++;
      end
      check("awaited output", pick(sel), v);
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == TIMEOUT_CYC) begin
         mismatches++;
         close_out;
      end
   end
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_normal;
      cmd = 4'hf;
      cyc(1);
      check("full on", {ch_out, nl_act}, 8'hf0);
      cyc(3);
      check("no limit", {ch_out, nl_act}, 8'hf0);
      cmd = 4'h0;
      cyc(1);
   endtask
   task automatic t_limit_retry;
      cmd = 4'h1;
      short_ld = 4'h1;
      cyc(1);
      check("limit at on", {ch_out[0], nl_act[0]}, 2'b11);
      cyc(3);
      check("still limiting", nl_act[0], 1'b1);
      cyc(1);
      check("shutdown", {ch_out[0], sd_flag[0], flt_oe_n}, 3'b010);
      repeat (7) begin
         cyc(1);
         check("held off", ch_out[0], 1'b0);
      end
      wait_for(0, 1'b1, 12);
      check("flag cleared", sd_flag[0], 1'b0);
      check("retry limited", nl_act[0], 1'b1);
      short_ld = 4'h0;
      cyc(1);
      check("back to full on", {ch_out[0], nl_act[0]}, 2'b10);
      cmd = 4'h0;
      cyc(1);
   endtask
   task automatic t_overtemp;
      cmd = 4'h1;
      short_ld = 4'h1;
      wait_for(2, 1'b1, 10);
      over_temp = 1'b1;
      repeat (20) begin
         cyc(1);
         check("retry suppressed", {ch_out[0], flt_oe_n}, 2'b00);
      end
      over_temp = 1'b0;
      wait_for(0, 1'b1, 20);
      cmd = 4'h0;
      short_ld = 4'h0;
      cyc(1);
   endtask
   task automatic t_peak_fail;
      cmd = 4'h1;
      short_ld = 4'h1;
      peak_ld = 4'h1;
      wait_for(1, 1'b1, 200);
      cyc(2);
      check("peak test on", pk_act[0], 1'b1);
      cyc(1);
      check("peak fail", {pk_act[0], ch_out[0], sd_flag[0]}, 3'b001);
      short_ld = 4'h0;
      peak_ld = 4'h0;
      repeat (6) begin
         cyc(1);
         check("blind while off", ch_out[0], 1'b0);
      end
      wait_for(0, 1'b1, 20);
      cyc(1);
      check("normal again", {nl_act[0], pk_act[0], ch_out[0]}, 3'b001);
      cmd = 4'h0;
      cyc(1);
   endtask
   task automatic t_inrush;
      int n;
      n = 0;
      cmd = 4'h1;
      short_ld = 4'h1;
      wait_for(1, 1'b1, 200);
      while (pk_act[0] === 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      check("inrush length", n, PL);
      check("inrush shutdown", {ch_out[0], sd_flag[0]}, 2'b01);
      cmd = 4'h0;
      short_ld = 4'h0;
      cyc(1);
   endtask
   task automatic t_clamp;
      cmd = 4'h3;
      clamp_over = 4'hf;
      beyond = 4'ha;
      cyc(3);
      check("clamp only off", {cl_low, cl_eng}, 8'hc8);
      cmd = 4'h0;
      cyc(2);
      check("low clamp", {cl_low, cl_eng}, 8'hfa);
      clamp_over = 4'h0;
      cyc(2);
      check("high clamp", cl_low, 4'h0);
      beyond = 4'h0;
      cyc(1);
   endtask
   initial begin
      {rst_n, cmd, short_ld, peak_ld} = '0;
      {clamp_over, beyond, over_temp, diag_clear} = '0;
      cyc(5);
      check("reset outputs", {ch_out, nl_act, pk_act, sd_flag}, 16'h0);
      check("reset pin", {flt_oe_n, flt_out, cl_low, cl_eng}, 10'h200);
      rst_n = 1'b1;
      cyc(1);
      t_normal();
      t_limit_retry();
      t_overtemp();
      t_peak_fail();
      t_inrush();
      t_clamp();
      close_out();
   end
endmodule
`default_nettype wire

/* File: logic/ocs_clamp_sel.sv */
/*
 * Demagnetization clamp level selection and off-state clamp engagement.
 * Assumes clamp current and output voltage indications are synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module ocs_clamp_sel (
   input wire logic sys_clk,
   input wire logic rst_n,
   ocs_link_if.clamp lnk
);
   import ocs_pkg::*;

   // Low level while the channel is off and the clamp current is above threshold, else high.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         lnk.clamp_low <= '0;
      end else begin
         lnk.clamp_low <= ~lnk.chan_on & lnk.clamp_over;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         lnk.clamp_eng <= '0;
      end else begin
         lnk.clamp_eng <= ~lnk.chan_on & lnk.out_high;
      end
   end
endmodule
`default_nettype wire

/* File: logic/ocs_fault_hold.sv */
/*
 * Fault indicator hold timer driving the open-drain enable, active low.
 * Assumes report is a one-cycle pulse per new diagnostic report.
 */
`timescale 1ns/1ps
`default_nettype none
module ocs_fault_hold #(
   parameter ocs_pkg::ocs_cnt_t HOLD_CYC = ocs_pkg::FAULT_HOLD_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   ocs_link_if.hold lnk
);
   import ocs_pkg::*;

   ocs_cnt_t hold_reg;
   ocs_cnt_t hold_next;

   // A new report restarts the window; a lasting fault re-arms it.
   always_comb begin
      hold_next = hold_reg;
      if (lnk.report) begin
         hold_next = HOLD_CYC;
      end else if (lnk.fault_present && hold_reg <= CNT_ONE) begin
         hold_next = HOLD_CYC;
      end else if (hold_reg != CNT_RST) begin
         hold_next = hold_reg - CNT_ONE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         hold_reg <= CNT_RST;
      end else begin
         hold_reg <= hold_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         lnk.flt_oe_n <= 1'b1;
      end else begin
         lnk.flt_oe_n <= (hold_next == CNT_RST);
      end
   end
endmodule
`default_nettype wire

/* File: logic/ocs_top.sv */
/*
 * Per-channel over-current protection sequencer with retry, inrush peak
 * test, shutdown flags, clamp level selection and fault indicator.
 * Assumes all inputs are synchronous to sys_clk and come from analog
 * comparators that are outside this block.
 */
// Overview of operation
// - High clamp current selects low clamp level.
// - Current below threshold selects high clamp level.
// - Off channel clamps when output exceeds high.
// - Over-current only above limit-detect threshold.
// - Persistent pulse shuts channel, sets flag.
// - Stay off for full retry delay.
// - Delay expiry clears flag, retries turn-on.
// - Retry each period, within protection window.
// - Over-current gone returns channel to full-on.
// - Four-channel option tests with peak limit.
// - Failed peak test shuts down, repeats.
// - Shutdown ignores current; waits retry period.
// - Inrush keeps raised limit up to peak pulse.
// - Still over threshold after peak pulse shuts.
// - Inrush exists only on four-channel option.
// - Flag auto-clear defaults to enabled.
// - Over-current at turn-on engages normal limit.
// - Fault indicator held per report, restartable.
// - Over-temperature suppresses retries within window.
`timescale 1ns/1ps
`default_nettype none
module ocs_top #(
   parameter ocs_pkg::ocs_cnt_t LIMIT_PULSE_CYC =
      ocs_pkg::CURRENT_LIMIT_PULSE_CYC,
   parameter ocs_pkg::ocs_cnt_t DELAY_CYC = ocs_pkg::RETRY_DELAY_CYC,
   parameter ocs_pkg::ocs_cnt_t PERIOD_CYC = ocs_pkg::RETRY_PERIOD_CYC,
   parameter ocs_pkg::ocs_cnt_t WINDOW_CYC = ocs_pkg::PROTECTION_WINDOW_CYC,
   parameter ocs_pkg::ocs_cnt_t PEAK_TEST_CYC = ocs_pkg::PEAK_TEST_PULSE_CYC,
   parameter ocs_pkg::ocs_cnt_t PEAK_LIMIT_CYC =
      ocs_pkg::PEAK_LIMIT_PULSE_CYC,
   parameter ocs_pkg::ocs_cnt_t HOLD_CYC = ocs_pkg::FAULT_HOLD_CYC,
   parameter bit FOUR_CH_OPTION = 1'b1,
   parameter bit DIAG_AUTOCLEAR = 1'b1
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [ocs_pkg::NUM_CH-1:0] channel_control_input,
   input wire logic [ocs_pkg::NUM_CH-1:0] over_limit_detect,
   input wire logic [ocs_pkg::NUM_CH-1:0] over_peak_limit,
   input wire logic [ocs_pkg::NUM_CH-1:0] clamp_over_threshold,
   input wire logic [ocs_pkg::NUM_CH-1:0] output_beyond_high_clamp,
   input wire logic over_temp_any,
   input wire logic diag_clear,
   output logic [ocs_pkg::NUM_CH-1:0] channel_output,
   output logic [ocs_pkg::NUM_CH-1:0] normal_limit_active,
   output logic [ocs_pkg::NUM_CH-1:0] peak_limit_active,
   output logic [ocs_pkg::NUM_CH-1:0] overcurrent_shutdown_flag,
   output logic [ocs_pkg::NUM_CH-1:0] clamp_low_select,
   output logic [ocs_pkg::NUM_CH-1:0] clamp_engage,
   output logic fault_indicator_n_out,
   output logic fault_indicator_n_oe_n
);
   import ocs_pkg::*;

   // ------------------------------------------------------------------
   // Option settings
   // ------------------------------------------------------------------

   // The peak current test only exists on the four-channel option.
   localparam bit INRUSH_EN = FOUR_CH_OPTION;
   localparam bit AUTOCLEAR_EN = DIAG_AUTOCLEAR;

   // ------------------------------------------------------------------
   // Per-channel state
   // ------------------------------------------------------------------
   ocs_state_e state_reg [NUM_CH];
   ocs_state_e state_next [NUM_CH];
   ocs_cnt_t elapsed_reg [NUM_CH];
   ocs_cnt_t delay_reg [NUM_CH];
   ocs_cnt_t period_reg [NUM_CH];
   ocs_cnt_t window_reg [NUM_CH];
   logic [NUM_CH-1:0] chan_on_reg;
   logic [NUM_CH-1:0] limit_reg;
   logic [NUM_CH-1:0] peak_reg;
   logic [NUM_CH-1:0] flag_reg;
   logic [NUM_CH-1:0] shut_evt;
   logic [NUM_CH-1:0] retry_evt;

   ocs_link_if lnk ();

   // ------------------------------------------------------------------
   // Channel sequencers
   // ------------------------------------------------------------------
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic det;
      logic peak_over;
      logic pulse_done;
      logic test_done;
      logic plim_done;
      logic delay_done;
      logic period_done;
      logic window_done;
      logic retry_block;
      logic in_pulse_now;
      logic in_pulse_next;

      assign det = over_limit_detect[c];
      assign peak_over = over_peak_limit[c];
      assign pulse_done = (elapsed_reg[c] >= LIMIT_PULSE_CYC - CNT_ONE);
      assign test_done = (elapsed_reg[c] >= PEAK_TEST_CYC - CNT_ONE);
      assign plim_done = (elapsed_reg[c] >= PEAK_LIMIT_CYC - CNT_ONE);
      assign delay_done = (delay_reg[c] >= DELAY_CYC - CNT_ONE);
      assign period_done = (period_reg[c] >= PERIOD_CYC - CNT_ONE);
      assign window_done = (window_reg[c] >= WINDOW_CYC - CNT_ONE);
      // Over-temperature holds back retries while the window runs.
      assign retry_block = over_temp_any & ~window_done;
      assign in_pulse_now = (state_reg[c] == OCS_LIMIT) ||
                            (state_reg[c] == OCS_PEAK);
      assign in_pulse_next = (state_next[c] == OCS_LIMIT) ||
                             (state_next[c] == OCS_PEAK);

      // Next state. A low control input always turns the channel off.
      always_comb begin
         state_next[c] = state_reg[c];
         shut_evt[c] = 1'b0;
         retry_evt[c] = 1'b0;
         if (!channel_control_input[c]) begin
            state_next[c] = OCS_IDLE;
         end else begin
            unique case (state_reg[c])
               OCS_IDLE: begin
                  if (det) begin
                     state_next[c] = OCS_LIMIT;
                  end else begin
                     state_next[c] = OCS_ON;
                  end
               end
               OCS_ON: begin
                  if (det) begin
                     state_next[c] = OCS_LIMIT;
                  end
               end
               OCS_LIMIT: begin
                  if (!det) begin
                     state_next[c] = OCS_ON;
                  end else if (pulse_done) begin
                     state_next[c] = OCS_SHUT;
                     shut_evt[c] = 1'b1;
                  end
               end
               OCS_PEAK: begin
                  if (!det) begin
                     state_next[c] = OCS_ON;
                  end else if ((peak_over && test_done) || plim_done) begin
                     // Peak test failed or inrush ran past its pulse.
                     state_next[c] = OCS_SHUT;
                     shut_evt[c] = 1'b1;
                  end
               end
               OCS_SHUT: begin
                  // Current is not looked at while shut down.
                  if (delay_done && period_done && !retry_block) begin
                     retry_evt[c] = 1'b1;
                     if (!window_done) begin
                        state_next[c] = OCS_LIMIT;
                     end else if (INRUSH_EN) begin
                        state_next[c] = OCS_PEAK;
                     end else begin
                        state_next[c] = OCS_LOCK;
                     end
                  end
               end
               OCS_LOCK: begin
                  state_next[c] = OCS_LOCK;
               end
               default: begin
                  state_next[c] = OCS_IDLE;
               end
            endcase
         end
      end

      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            state_reg[c] <= OCS_IDLE;
         end else begin
            state_reg[c] <= state_next[c];
         end
      end

      // Time spent in the current limited pulse, zero on entry.
      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            elapsed_reg[c] <= CNT_RST;
         end else if (!in_pulse_next || state_next[c] != state_reg[c]) begin
            elapsed_reg[c] <= CNT_RST;
         end else if (elapsed_reg[c] != CNT_MAX) begin
            elapsed_reg[c] <= elapsed_reg[c] + CNT_ONE;
         end
      end

      // Time spent shut down.
      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            delay_reg[c] <= CNT_RST;
         end else if (state_next[c] != OCS_SHUT) begin
            delay_reg[c] <= CNT_RST;
         end else if (state_reg[c] == OCS_SHUT && delay_reg[c] != CNT_MAX) begin
            delay_reg[c] <= delay_reg[c] + CNT_ONE;
         end
      end

      // Time since the start of the latest attempt.
      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            period_reg[c] <= CNT_RST;
         end else if (in_pulse_next && !in_pulse_now) begin
            period_reg[c] <= CNT_RST;
         end else if (period_reg[c] != CNT_MAX) begin
            period_reg[c] <= period_reg[c] + CNT_ONE;
         end
      end

      // Length of the present over-current episode.
      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            window_reg[c] <= CNT_RST;
         end else if (state_reg[c] == OCS_IDLE || state_reg[c] == OCS_ON) begin
            window_reg[c] <= CNT_RST;
         end else if (window_reg[c] != CNT_MAX) begin
            window_reg[c] <= window_reg[c] + CNT_ONE;
         end
      end

      // Switch drive and limit selection follow the next state.
      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            chan_on_reg[c] <= 1'b0;
            limit_reg[c] <= 1'b0;
            peak_reg[c] <= 1'b0;
         end else begin
            chan_on_reg[c] <= (state_next[c] == OCS_ON) || in_pulse_next;
            limit_reg[c] <= (state_next[c] == OCS_LIMIT);
            peak_reg[c] <= (state_next[c] == OCS_PEAK);
         end
      end

      // Shutdown flag: a new shutdown wins over a clear in the same cycle.
      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            flag_reg[c] <= 1'b0;
         end else if (shut_evt[c]) begin
            flag_reg[c] <= 1'b1;
         end else if (AUTOCLEAR_EN && retry_evt[c]) begin
            flag_reg[c] <= 1'b0;
         end else if (!AUTOCLEAR_EN && diag_clear) begin
            flag_reg[c] <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Clamp selection and fault indicator helpers
   // ------------------------------------------------------------------
   assign lnk.chan_on = chan_on_reg;
   assign lnk.clamp_over = clamp_over_threshold;
   assign lnk.out_high = output_beyond_high_clamp;
   assign lnk.report = |shut_evt;
   assign lnk.fault_present = |flag_reg;

   ocs_clamp_sel u_clamp (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .lnk(lnk.clamp)
   );

   ocs_fault_hold #(
      .HOLD_CYC(HOLD_CYC)
   ) u_hold (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .lnk(lnk.hold)
   );

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign channel_output = chan_on_reg;
   assign normal_limit_active = limit_reg;
   assign peak_limit_active = peak_reg;
   assign overcurrent_shutdown_flag = flag_reg;
   assign clamp_low_select = lnk.clamp_low;
   assign clamp_engage = lnk.clamp_eng;
   // The open-drain pin only ever pulls low; the enable carries the state.
   assign fault_indicator_n_out = 1'b0;
   assign fault_indicator_n_oe_n = lnk.flt_oe_n;
endmodule
`default_nettype wire

/* File: shared/ocs_link_if.sv */
/*
 * Internal carrier between the sequencer top and its clamp and fault-hold
 * helpers.
 * Assumes all parties run on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
interface ocs_link_if;
   import ocs_pkg::*;
   logic [NUM_CH-1:0] chan_on;
   logic [NUM_CH-1:0] clamp_over;
   logic [NUM_CH-1:0] out_high;
   logic [NUM_CH-1:0] clamp_low;
   logic [NUM_CH-1:0] clamp_eng;
   logic report;
   logic fault_present;
   logic flt_oe_n;
   modport top (output chan_on, clamp_over, out_high, report, fault_present,
                input clamp_low, clamp_eng, flt_oe_n);
   modport clamp (input chan_on, clamp_over, out_high,
                  output clamp_low, clamp_eng);
   modport hold (input report, fault_present, output flt_oe_n);
endinterface
`default_nettype wire

/* File: shared/ocs_pkg.sv */
/*
 * Shared constants, timing figures and state codes for the over-current
 * and clamp sequencer.
 * Assumes a single 50 MHz system clock; all times are converted to cycles.
 */
package ocs_pkg;

   // ------------------------------------------------------------------
   // Structure
   // ------------------------------------------------------------------
   localparam int NUM_CH = 4;
   localparam int CNT_W = 24;
   typedef logic [CNT_W-1:0] ocs_cnt_t;
   localparam ocs_cnt_t CNT_RST = 24'h000000;
   localparam ocs_cnt_t CNT_ONE = 24'h000001;
   localparam ocs_cnt_t CNT_MAX = 24'hffffff;

   // ------------------------------------------------------------------
   // Protection times in microseconds
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int CURRENT_LIMIT_PULSE_US = 50;
   localparam int RETRY_DELAY_US = 1000;
   localparam int RETRY_PERIOD_US = 2000;
   localparam int PROTECTION_WINDOW_US = 20000;
   localparam int PEAK_TEST_PULSE_US = 20;
   localparam int PEAK_LIMIT_PULSE_US = 20000;
   localparam int FAULT_HOLD_US = 1000;

   // Least times: round up to whole cycles, never below one.
   function automatic ocs_cnt_t ocs_us_to_cyc(input int us);
      int cyc;
      cyc = (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      if (cyc < 1) begin
         cyc = 1;
      end
      return ocs_cnt_t'(cyc);
   endfunction

   localparam ocs_cnt_t CURRENT_LIMIT_PULSE_CYC =
      ocs_us_to_cyc(CURRENT_LIMIT_PULSE_US);
   localparam ocs_cnt_t RETRY_DELAY_CYC = ocs_us_to_cyc(RETRY_DELAY_US);
   localparam ocs_cnt_t RETRY_PERIOD_CYC = ocs_us_to_cyc(RETRY_PERIOD_US);
   localparam ocs_cnt_t PROTECTION_WINDOW_CYC =
      ocs_us_to_cyc(PROTECTION_WINDOW_US);
   localparam ocs_cnt_t PEAK_TEST_PULSE_CYC =
      ocs_us_to_cyc(PEAK_TEST_PULSE_US);
   localparam ocs_cnt_t PEAK_LIMIT_PULSE_CYC =
      ocs_us_to_cyc(PEAK_LIMIT_PULSE_US);
   localparam ocs_cnt_t FAULT_HOLD_CYC = ocs_us_to_cyc(FAULT_HOLD_US);

   // ------------------------------------------------------------------
   // Channel sequencer states
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      OCS_IDLE = 3'b000,
      OCS_ON = 3'b001,
      OCS_LIMIT = 3'b010,
      OCS_PEAK = 3'b011,
      OCS_SHUT = 3'b100,
      OCS_LOCK = 3'b101
   } ocs_state_e;

endpackage
